// File: include/gcb_pkg.sv
// gcb_pkg: shared types and constants of the gateway control byte decoder.
// assumes a single 200 MHz clock domain; the fieldbus image arrives on that clock.
package gcb_pkg;

    // clock and timing
    localparam int unsigned CLK_KHZ        = 200000;          // 200 MHz system clock
    localparam int unsigned WIPE_HOLD_MS   = 20;              // pattern must stand longer
    localparam int unsigned WIPE_HOLD_CYC  = WIPE_HOLD_MS * CLK_KHZ;
    localparam int unsigned WIPE_CNT_W     = 32;

    // wipe pattern value on all four checked bytes
    localparam logic [7:0]  WIPE_BYTE      = 8'hAA;

    // field positions, first control byte
    localparam int unsigned C0_CMD_BIT     = 0;
    localparam int unsigned C0_BCAST_BIT   = 1;
    localparam int unsigned C0_ADDR_LSB    = 2;
    localparam int unsigned C0_FRESH_BIT   = 7;
    // field positions, second control byte
    localparam int unsigned C1_RDACK_BIT   = 0;
    localparam int unsigned C1_FLUSH_BIT   = 2;
    localparam int unsigned C1_STAGE_BIT   = 3;

    // values after reset
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic        TOGGLE_RESET   = 1'b0;

    // first control byte layout, msb first
    typedef struct packed {
        logic       fresh_data_toggle;
        logic [4:0] station_addr;
        logic       broadcast;
        logic       command_mode;
    } gcb_ctrl_first_t;

    // second control byte layout, msb first; unused bits carried along
    typedef struct packed {
        logic [3:0] unused_hi;
        logic       stage_to_buffer_toggle;
        logic       flush_buffer_toggle;
        logic       unused_1;
        logic       read_ack_toggle;
    } gcb_ctrl_second_t;

    // output image: two control bytes, then data bytes 1 and 2 ascending
    typedef struct packed {
        gcb_ctrl_first_t  output_control_first;
        gcb_ctrl_second_t output_control_second;
        logic [7:0]       data_byte_1;
        logic [7:0]       data_byte_2;
    } gcb_image_t;

    // prefix placed ahead of an outgoing telegram
    typedef enum logic [1:0] {
        GCB_PFX_NONE  = 2'b00,
        GCB_PFX_BCAST = 2'b01,
        GCB_PFX_ADDR  = 2'b10
    } gcb_prefix_t;

    // one outgoing telegram request or staging request
    typedef struct packed {
        gcb_prefix_t prefix;
        logic [4:0]  station_addr;
        logic [7:0]  data_byte_1;
        logic [7:0]  data_byte_2;
    } gcb_tx_req_t;

endpackage

// File: design/gcb_decoder.sv
// gcb_decoder: decodes the two cyclic control bytes written by the fieldbus controller.
// assumes img and cyc_valid come from fieldbus logic on clk_sys; img holds between cycles.
// How it works
// - first control byte bit 0 selects transparent (0, default) or command operation (1).
// - in command operation no new controller data is sent or staged; a flush toggle still sends staged data.
// - in command operation set data bits are passed on as device-specific commands.
// - broadcast bit set prepends the broadcast prefix ahead of outgoing data.
// - bits 2 to 6 give a binary station address placed ahead of the data.
// - broadcast and address take effect only with a concentrator attached.
// - every change of the fresh-data toggle counts as new data, repeats included.
// - second byte: bit 0 read ack, bit 2 flush, bit 3 stage; rest unused.
// - data bytes follow the control bytes, data byte 1 first.
// - read-ack change loads next receive bytes and toggles block-ready.
// - stage toggle change copies controller data into the transmit buffer instead.
// - flush toggle change sends all staged data out of the serial port.
// - all four bytes AAh for over 20 ms clears buffer and status bits.
`timescale 1ns/1ps
`default_nettype none

module gcb_decoder #(
    parameter int unsigned WIPE_HOLD_CYCLES = gcb_pkg::WIPE_HOLD_CYC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic                 cyc_valid,
    input  wire gcb_pkg::gcb_image_t  img,
    input  wire logic                 concentrator_attached,
    output logic                      command_mode_r,
    output logic                      tx_valid_r,
    output gcb_pkg::gcb_tx_req_t      tx_req_r,
    output logic                      stage_valid_r,
    output logic                      flush_r,
    output logic                      cmd_valid_r,
    output logic [15:0]               cmd_bits_r,
    output logic                      rx_load_r,
    output logic                      block_ready_toggle_r,
    output logic                      wipe_r
);

    logic                            rst_meta_r;
    logic                            rst_n_r;
    logic                            hist_fresh_r;
    logic                            hist_rdack_r;
    logic                            hist_flush_r;
    logic                            hist_stage_r;
    logic [gcb_pkg::WIPE_CNT_W-1:0]  wipe_cnt_r;
    logic                            fresh_chg;
    logic                            rdack_chg;
    logic                            flush_chg;
    logic                            stage_chg;
    logic                            pattern;
    logic                            wipe_fire;
    gcb_pkg::gcb_tx_req_t            req_nxt;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // toggle change detection against previous cycle
    assign fresh_chg = cyc_valid &&
        (img.output_control_first.fresh_data_toggle != hist_fresh_r);
    assign rdack_chg = cyc_valid &&
        (img.output_control_second.read_ack_toggle != hist_rdack_r);
    assign flush_chg = cyc_valid &&
        (img.output_control_second.flush_buffer_toggle != hist_flush_r);
    assign stage_chg = cyc_valid &&
        (img.output_control_second.stage_to_buffer_toggle != hist_stage_r);

    // wipe pattern on both control bytes and first two data bytes
    assign pattern = (img.output_control_first == gcb_pkg::WIPE_BYTE) &&
                     (img.output_control_second == gcb_pkg::WIPE_BYTE) &&
                     (img.data_byte_1 == gcb_pkg::WIPE_BYTE) &&
                     (img.data_byte_2 == gcb_pkg::WIPE_BYTE);
    assign wipe_fire = pattern && (wipe_cnt_r == gcb_pkg::WIPE_CNT_W'(WIPE_HOLD_CYCLES));

    // prefix selection, ignored without a concentrator
    always_comb begin
        req_nxt.prefix       = gcb_pkg::GCB_PFX_NONE;
        req_nxt.station_addr = img.output_control_first.station_addr;
        req_nxt.data_byte_1  = img.data_byte_1;
        req_nxt.data_byte_2  = img.data_byte_2;
        if (concentrator_attached) begin
            if (img.output_control_first.broadcast) begin
                req_nxt.prefix = gcb_pkg::GCB_PFX_BCAST;
            end else begin
                req_nxt.prefix = gcb_pkg::GCB_PFX_ADDR;
            end
        end
    end

    // toggle history, zero after reset and after a wipe
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            hist_fresh_r <= gcb_pkg::TOGGLE_RESET;
            hist_rdack_r <= gcb_pkg::TOGGLE_RESET;
            hist_flush_r <= gcb_pkg::TOGGLE_RESET;
            hist_stage_r <= gcb_pkg::TOGGLE_RESET;
        end else if (wipe_fire) begin
            hist_fresh_r <= gcb_pkg::TOGGLE_RESET;
            hist_rdack_r <= gcb_pkg::TOGGLE_RESET;
            hist_flush_r <= gcb_pkg::TOGGLE_RESET;
            hist_stage_r <= gcb_pkg::TOGGLE_RESET;
        end else if (cyc_valid) begin
            hist_fresh_r <= img.output_control_first.fresh_data_toggle;
            hist_rdack_r <= img.output_control_second.read_ack_toggle;
            hist_flush_r <= img.output_control_second.flush_buffer_toggle;
            hist_stage_r <= img.output_control_second.stage_to_buffer_toggle;
        end
    end

    // mode bit follows each fieldbus cycle
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            command_mode_r <= gcb_pkg::CTRL_RESET[gcb_pkg::C0_CMD_BIT];
        end else if (wipe_fire) begin
            command_mode_r <= gcb_pkg::CTRL_RESET[gcb_pkg::C0_CMD_BIT];
        end else if (cyc_valid) begin
            command_mode_r <= img.output_control_first.command_mode;
        end
    end

    // outgoing data: direct send, staging or command
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_valid_r    <= 1'b0;
            stage_valid_r <= 1'b0;
            cmd_valid_r   <= 1'b0;
            tx_req_r      <= '0;
            cmd_bits_r    <= 16'h0000;
        end else begin
            tx_valid_r    <= 1'b0;
            stage_valid_r <= 1'b0;
            cmd_valid_r   <= 1'b0;
            if (fresh_chg && !wipe_fire) begin
                if (img.output_control_first.command_mode) begin
                    cmd_valid_r <= 1'b1;
                    cmd_bits_r  <= {img.data_byte_1, img.data_byte_2};
                end else if (stage_chg) begin
                    stage_valid_r <= 1'b1;
                    tx_req_r      <= req_nxt;
                end else begin
                    tx_valid_r <= 1'b1;
                    tx_req_r   <= req_nxt;
                end
            end else if (stage_chg && !wipe_fire &&
                         !img.output_control_first.command_mode) begin
                stage_valid_r <= 1'b1;
                tx_req_r      <= req_nxt;
            end
        end
    end

    // flush of staged data
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flush_r <= 1'b0;
        end else begin
            flush_r <= flush_chg && !wipe_fire;
        end
    end

    // read acknowledge: load receive bytes, flip block-ready
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_load_r            <= 1'b0;
            block_ready_toggle_r <= gcb_pkg::TOGGLE_RESET;
        end else if (wipe_fire) begin
            rx_load_r            <= 1'b0;
            block_ready_toggle_r <= gcb_pkg::TOGGLE_RESET;
        end else begin
            rx_load_r <= rdack_chg;
            if (rdack_chg) begin
                block_ready_toggle_r <= !block_ready_toggle_r;
            end
        end
    end

    // wipe pattern hold counter, fires once per hold
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wipe_cnt_r <= '0;
            wipe_r     <= 1'b0;
        end else begin
            wipe_r <= wipe_fire;
            if (!pattern) begin
                wipe_cnt_r <= '0;
            end else if (wipe_cnt_r <= gcb_pkg::WIPE_CNT_W'(WIPE_HOLD_CYCLES)) begin
                wipe_cnt_r <= wipe_cnt_r + 1'b1;                                  // saturates
            end
        end
    end

    // checks
    property p_no_fwd_cmd;
        @(posedge clk_sys) disable iff (!rst_n_r)
        tx_valid_r |-> !$past(img.output_control_first.command_mode);
    endproperty
    a_no_fwd_cmd: assert property (p_no_fwd_cmd) else $error("data sent in command mode");

    property p_cmd_bits;
        @(posedge clk_sys) disable iff (!rst_n_r)
        cmd_valid_r |-> cmd_bits_r == $past({img.data_byte_1, img.data_byte_2});
    endproperty
    a_cmd_bits: assert property (p_cmd_bits) else $error("command bits mismatch");

    property p_bcast;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (tx_valid_r && tx_req_r.prefix == gcb_pkg::GCB_PFX_BCAST)
            |-> $past(img.output_control_first.broadcast && concentrator_attached);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast without cause");

    property p_addr;
        @(posedge clk_sys) disable iff (!rst_n_r)
        tx_valid_r |-> tx_req_r.station_addr == $past(img.output_control_first.station_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("station address mismatch");

    property p_no_conc;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (tx_valid_r && !$past(concentrator_attached)) |-> tx_req_r.prefix == gcb_pkg::GCB_PFX_NONE;
    endproperty
    a_no_conc: assert property (p_no_conc) else $error("prefix without concentrator");

    property p_fresh;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (fresh_chg && !stage_chg && !wipe_fire && !img.output_control_first.command_mode)
            |=> tx_valid_r && tx_req_r.data_byte_1 == $past(img.data_byte_1);
    endproperty
    a_fresh: assert property (p_fresh) else $error("fresh data not sent");

    property p_rdack;
        @(posedge clk_sys) disable iff (!rst_n_r)
        rx_load_r |-> block_ready_toggle_r != $past(block_ready_toggle_r);
    endproperty
    a_rdack: assert property (p_rdack) else $error("block ready not toggled");

    property p_stage;
        @(posedge clk_sys) disable iff (!rst_n_r)
        stage_valid_r |-> !tx_valid_r && $past(stage_chg);
    endproperty
    a_stage: assert property (p_stage) else $error("staging sent directly");

    property p_flush;
        @(posedge clk_sys) disable iff (!rst_n_r)
        (flush_chg && !wipe_fire) |=> flush_r;
    endproperty
    a_flush: assert property (p_flush) else $error("flush missed");

    property p_wipe;
        @(posedge clk_sys) disable iff (!rst_n_r)
        wipe_r |-> !block_ready_toggle_r && !command_mode_r && $past(pattern, 2);
    endproperty
    a_wipe: assert property (p_wipe) else $error("wipe incomplete");

    property p_quiet;
        @(posedge clk_sys) disable iff (!rst_n_r)
        !cyc_valid |=> !tx_valid_r && !stage_valid_r && !flush_r && !rx_load_r;
    endproperty
    a_quiet: assert property (p_quiet) else $error("action without fieldbus cycle");

    c_tx_bcast: cover property (@(posedge clk_sys) disable iff (!rst_n_r)
        tx_valid_r && tx_req_r.prefix == gcb_pkg::GCB_PFX_BCAST);
    c_stage_flush: cover property (@(posedge clk_sys) disable iff (!rst_n_r)
        stage_valid_r ##[1:20] flush_r);
    c_cmd: cover property (@(posedge clk_sys) disable iff (!rst_n_r) cmd_valid_r);
    c_wipe: cover property (@(posedge clk_sys) disable iff (!rst_n_r) wipe_r);

endmodule

`default_nettype wire

// File: bench/gcb_serial_model.sv
// gcb_serial_model: serial end device side with a transmit buffer in front of it.
// assumes the decoder's pulses are one clk_sys cycle long.
`timescale 1ns/1ps
`default_nettype none

module gcb_serial_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic tx_valid_r,
    input  wire logic stage_valid_r,
    input  wire logic flush_r,
    input  wire logic wipe_r,
    output logic [7:0] sent_cnt,
    output logic [7:0] staged_cnt
);
    // direct sends go out at once; staged ones wait for a flush
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sent_cnt   <= 8'h00;
            staged_cnt <= 8'h00;
        end else if (wipe_r) begin
            staged_cnt <= 8'h00; // buffer cleared
        end else begin
            if (stage_valid_r) staged_cnt <= staged_cnt + 8'h01;
            if (flush_r) staged_cnt <= 8'h00;
            sent_cnt <= sent_cnt + {7'h00, tx_valid_r} + (flush_r ? staged_cnt : 8'h00);
        end
    end
endmodule

`default_nettype wire

// File: bench/gcb_decoder_tb.sv
// gcb_decoder_tb: drives fieldbus images and checks decoded pulses and fields.
// assumes the decoder with a short wipe hold and the serial model beside it.
`timescale 1ns/1ps
`default_nettype none

module gcb_decoder_tb;
    localparam int unsigned HOLD = 8;
    logic clk_sys, resetn, cyc_valid, concentrator_attached;
    gcb_pkg::gcb_image_t img;
    gcb_pkg::gcb_tx_req_t tx_req_r;
    logic command_mode_r, tx_valid_r, stage_valid_r, flush_r, cmd_valid_r;
    logic rx_load_r, block_ready_toggle_r, wipe_r;
    logic [15:0] cmd_bits_r;
    logic [7:0] sent_cnt, staged_cnt;
    int num_errors, n_compared, seen;
    logic br;

    gcb_decoder #(.WIPE_HOLD_CYCLES(HOLD)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .cyc_valid(cyc_valid), .img(img),
        .concentrator_attached(concentrator_attached), .command_mode_r(command_mode_r),
        .tx_valid_r(tx_valid_r), .tx_req_r(tx_req_r), .stage_valid_r(stage_valid_r),
        .flush_r(flush_r), .cmd_valid_r(cmd_valid_r), .cmd_bits_r(cmd_bits_r),
        .rx_load_r(rx_load_r), .block_ready_toggle_r(block_ready_toggle_r), .wipe_r(wipe_r));

    gcb_serial_model far_end (
        .clk_sys(clk_sys), .resetn(resetn), .tx_valid_r(tx_valid_r),
        .stage_valid_r(stage_valid_r), .flush_r(flush_r), .wipe_r(wipe_r),
        .sent_cnt(sent_cnt), .staged_cnt(staged_cnt));

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // one comparison with report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one fieldbus cycle; ex = {tx, stage, flush, cmd, rx}
    task automatic cycle(input logic [7:0] c0, c1, d1, d2, input logic [4:0] ex);
        logic [1:0] pf;
        pf = !concentrator_attached ? gcb_pkg::GCB_PFX_NONE :
             c0[1] ? gcb_pkg::GCB_PFX_BCAST : gcb_pkg::GCB_PFX_ADDR;
        @(posedge clk_sys);
        #1;
        img = gcb_pkg::gcb_image_t'({c0, c1, d1, d2});
        cyc_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        cyc_valid = 1'b0;
        if (ex[0]) br = ~br;
        chk("pulses", {27'h0, ex},
            {27'h0, tx_valid_r, stage_valid_r, flush_r, cmd_valid_r, rx_load_r});
        chk("command_mode", {31'h0, c0[0]}, {31'h0, command_mode_r});
        chk("block_ready", {31'h0, br}, {31'h0, block_ready_toggle_r});
        if (ex[4] | ex[3]) begin
            chk("prefix", {30'h0, pf}, {30'h0, tx_req_r.prefix});
            chk("data", {16'h0, d1, d2},
                {16'h0, tx_req_r.data_byte_1, tx_req_r.data_byte_2});
            if (pf == gcb_pkg::GCB_PFX_ADDR)
                chk("addr", {27'h0, c0[6:2]}, {27'h0, tx_req_r.station_addr});
        end
        if (ex[1]) chk("cmd_bits", {16'h0, d1, d2}, {16'h0, cmd_bits_r});
        @(posedge clk_sys);
        #1;
        chk("pulse_end", 32'h0,
            {27'h0, tx_valid_r, stage_valid_r, flush_r, cmd_valid_r, rx_load_r});
    endtask

    initial begin
        num_errors = 0;
        n_compared = 0;
        br = 1'b0;
        resetn = 1'b0;
        cyc_valid = 1'b0;
        concentrator_attached = 1'b0;
        img = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("reset_outs", 32'h0, {24'h0, command_mode_r, tx_valid_r, stage_valid_r, flush_r,
            cmd_valid_r, rx_load_r, block_ready_toggle_r, wipe_r});
        cycle(8'h80, 8'h00, 8'h11, 8'h22, 5'b10000);
        cycle(8'h00, 8'h00, 8'h11, 8'h22, 5'b10000);
        cycle(8'h00, 8'h00, 8'h11, 8'h22, 5'b00000);
        cycle(8'h00, 8'hF2, 8'h11, 8'h22, 5'b00000);
        concentrator_attached = 1'b1;
        cycle(8'h82, 8'hF2, 8'h33, 8'h44, 5'b10000);
        cycle(8'h7C, 8'hF2, 8'h55, 8'h66, 5'b10000);
        cycle(8'h84, 8'hF2, 8'h77, 8'h88, 5'b10000);
        cycle(8'h05, 8'hF2, 8'h12, 8'h34, 5'b00010);
        cycle(8'h05, 8'hFA, 8'h12, 8'h34, 5'b00000);
        cycle(8'h84, 8'hF2, 8'h9A, 8'hBC, 5'b01000);
        chk("staged", 32'h1, {24'h0, staged_cnt});
        cycle(8'h84, 8'hF6, 8'h9A, 8'hBC, 5'b00100);
        chk("sent", 32'h6, {24'h0, sent_cnt});
        cycle(8'h84, 8'hF7, 8'h00, 8'h00, 5'b00001);
        cycle(8'h84, 8'hF6, 8'h00, 8'h00, 5'b00001);
        cycle(8'h84, 8'hF7, 8'h00, 8'h00, 5'b00001);
        cycle(8'h85, 8'hF7, 8'h00, 8'h00, 5'b00000);
        // hold the clearing pattern without new cycles
        @(posedge clk_sys);
        #1;
        img = gcb_pkg::gcb_image_t'(32'hAAAAAAAA);
        seen = 0;
        for (int i = 1; i <= HOLD + 4 && seen == 0; i++) begin
            @(posedge clk_sys);
            #1;
            if (wipe_r === 1'b1) seen = i;
        end
        if (seen == 0) chk("wipe_timeout", 32'h1, 32'h0);
        chk("wipe_late_enough", 32'h1, {31'h0, seen >= HOLD});
        chk("wipe_clears", 32'h0, {30'h0, command_mode_r, block_ready_toggle_r});
        br = 1'b0;
        cycle(8'h80, 8'h00, 8'h99, 8'h88, 5'b10000);
        chk("sent_total", 32'h7, {24'h0, sent_cnt});
        tally_and_finish();
    end
endmodule

`default_nettype wire
